// File: verilog/phm_pkg.sv
// Shared constants and state types for the MII datapath timing block
package phm_pkg;

  localparam int CLK_NS          = 5;
  // One bit time is one line bit period at the selected speed
  localparam int BT100_NS        = 10;
  localparam int BT10_NS         = 100;
  localparam int BT100_CYC       = BT100_NS / CLK_NS;
  localparam int BT10_CYC        = BT10_NS / CLK_NS;

  localparam int TX_CRS_ON_BT    = 4;
  localparam int TX_CRS_OFF10_BT = 8;
  localparam int TX_CRS_OFF100_BT = 4;
  localparam int TX_LAT10_BT     = 4;
  localparam int TX_LAT100_BT    = 9;
  localparam int RX_LAT_BT       = 6;

  localparam int SQE_DLY_NS      = 2500;
  localparam int SQE_PW_NS       = 1000;
  localparam int SQE_DLY_CYC     = SQE_DLY_NS / CLK_NS;
  localparam int SQE_PW_CYC      = SQE_PW_NS / CLK_NS;

  localparam int RX_CRS_ON_MIN_NS  = 106;
  localparam int RX_CRS_ON_MAX_NS  = 138;
  localparam int RX_CRS_OFF_MIN_NS = 154;
  localparam int RX_CRS_OFF_MAX_NS = 186;
  // Aim at the middle of each window; the output flop adds one cycle
  localparam int RX_CRS_ON_CYC   = ((RX_CRS_ON_MIN_NS + RX_CRS_ON_MAX_NS) / 2) / CLK_NS;
  localparam int RX_CRS_OFF_CYC  = ((RX_CRS_OFF_MIN_NS + RX_CRS_OFF_MAX_NS) / 2) / CLK_NS;
  localparam int RX_LAT_CYC      = RX_LAT_BT * BT100_CYC;

  localparam int CNT_W           = 10;
  localparam int CDC_STAGES      = 2;
  localparam logic CRS_RST       = 1'b0;
  localparam logic COL_RST       = 1'b0;

  typedef enum logic [1:0] {TX_IDLE, TX_ACT, TX_TAIL} phm_tx_st_t;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_END} phm_rx_st_t;

endpackage

// File: verilog/phm_cdc_if.sv
// Bundle of level signals crossing into a clock domain
interface phm_cdc_if #(parameter int W = 1) ();
  logic [W-1:0] async_d;
  logic [W-1:0] sync_q;
  modport src (output async_d, input sync_q);
  modport syn (input async_d, output sync_q);
endinterface

// File: verilog/phm_cdc_sync.sv
// Two-flop level synchroniser for a bundle of independent bits
module phm_cdc_sync (
  input wire logic clk,
  input wire logic resetn,
  phm_cdc_if.syn   port
);
  localparam int W = $bits(port.async_d);

  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;

  // Each bit crosses on its own; no bundle coherence is promised
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      meta_ff <= '0;
      sync_ff <= '0;
    end
    else
    begin
      meta_ff <= port.async_d;
      sync_ff <= meta_ff;
    end
  end

  assign port.sync_q = sync_ff;
endmodule

// File: verilog/phm_datapath.sv
// MII-side transmit/receive timing of a 10/100 line transceiver
////////////////////////////////////////////////////////////////////////////////
module phm_datapath (
  input  wire logic       core_clk,
  input  wire logic       resetn,
  input  wire logic       mii_clk,
  input  wire logic       spd_100_pin,
  input  wire logic       tx_en,
  input  wire logic       tx_er,
  input  wire logic [3:0] txd,
  output logic            crs,
  output logic            col,
  output logic [3:0]      rxd,
  output logic            rx_er,
  output logic            rx_dv,
  input  wire logic       line_sos,
  input  wire logic       line_eos,
  input  wire logic       line_rx_stb,
  input  wire logic [3:0] line_rx_nib,
  input  wire logic       line_rx_err,
  output logic            line_transmit_pair_10m,
  output logic            line_tx_100m,
  output logic [3:0]      line_tx_nib,
  output logic            line_tx_err
);
  localparam int W = phm_pkg::CNT_W;
  localparam logic [W-1:0] CNT_MAX = '1;

  function automatic logic [W-1:0] bt_cyc(input int n_bt, input logic fast);
    bt_cyc = fast ? W'(n_bt * phm_pkg::BT100_CYC) : W'(n_bt * phm_pkg::BT10_CYC);
  endfunction

  function automatic logic [W-1:0] cnt_inc(input logic [W-1:0] c);
    cnt_inc = (c == CNT_MAX) ? c : c + W'(1);
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Link domain: capture from the MAC, launch toward the MAC
  logic       tx_en_l_ff;
  logic       tx_er_l_ff;
  logic [3:0] txd_l_ff;
  logic [3:0] rxd_ff;
  logic       rx_er_ff;
  logic       rx_dv_ff;
  logic       tog_d_ff;

  logic [4:0] hold_ff [2];
  logic       hold_tog_ff;
  logic       rxdv_c_ff;

  phm_cdc_if #(.W(2)) lsync ();
  assign lsync.async_d = {hold_tog_ff, rxdv_c_ff};

  phm_cdc_sync u_lsync (
    .clk    (mii_clk),
    .resetn (resetn),
    .port   (lsync)
  );

  wire       tog_s    = lsync.sync_q[1];
  wire       rxdv_s   = lsync.sync_q[0];
  wire       new_nib  = tog_s ^ tog_d_ff;
  wire [4:0] rd_slot  = hold_ff[tog_s];

  always_ff @(posedge mii_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      tx_en_l_ff <= 1'b0;
      tx_er_l_ff <= 1'b0;
      txd_l_ff   <= 4'h0;
    end
    else
    begin
      tx_en_l_ff <= tx_en;
      tx_er_l_ff <= tx_er;
      txd_l_ff   <= txd;
    end
  end

  // Slot tog_s is stable here: it is rewritten only two nibbles later
  always_ff @(posedge mii_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      tog_d_ff <= 1'b0;
      rx_dv_ff <= 1'b0;
      rxd_ff   <= 4'h0;
      rx_er_ff <= 1'b0;
    end
    else
    begin
      tog_d_ff <= tog_s;
      rx_dv_ff <= rxdv_s;
      rxd_ff   <= new_nib ? rd_slot[3:0] : rxd_ff;
      rx_er_ff <= new_nib ? rd_slot[4] : (rx_er_ff & rxdv_s);
    end
  end

  assign rxd         = rxd_ff;
  assign rx_er       = rx_er_ff;
  assign rx_dv       = rx_dv_ff;
  assign line_tx_nib = txd_l_ff;
  assign line_tx_err = tx_er_l_ff;

  ////////////////////////////////////////////////////////////////////////////////
  // Core domain: transmit-side carrier, line start and heartbeat
  phm_cdc_if #(.W(2)) csync ();
  assign csync.async_d = {spd_100_pin, tx_en_l_ff};

  phm_cdc_sync u_csync (
    .clk    (core_clk),
    .resetn (resetn),
    .port   (csync)
  );

  wire spd_s   = csync.sync_q[1];
  wire tx_en_s = csync.sync_q[0];

  phm_pkg::phm_tx_st_t tx_st_ff;
  phm_pkg::phm_tx_st_t nxt_tx_st;
  logic [W-1:0]        tx_cnt_ff;
  logic [W-1:0]        nxt_tx_cnt;
  logic                crs_tx_ff;
  logic                nxt_crs_tx;
  logic                line10_ff;
  logic                line100_ff;
  logic                col_ff;
  logic                crs_ff;

  localparam logic [W-1:0] SQE_N = W'(phm_pkg::SQE_DLY_CYC);
  localparam logic [W-1:0] PW_N  = W'(phm_pkg::SQE_PW_CYC);

  wire [W-1:0] crs_on_n  = bt_cyc(phm_pkg::TX_CRS_ON_BT, spd_s);
  wire [W-1:0] crs_off_n = spd_s ? bt_cyc(phm_pkg::TX_CRS_OFF100_BT, 1'b1)
                                 : bt_cyc(phm_pkg::TX_CRS_OFF10_BT, 1'b0);
  wire [W-1:0] lat_n     = spd_s ? bt_cyc(phm_pkg::TX_LAT100_BT, 1'b1)
                                 : bt_cyc(phm_pkg::TX_LAT10_BT, 1'b0);
  // At 10M the tail also covers the heartbeat window
  wire [W-1:0] tail_n    = spd_s ? crs_off_n : SQE_N + PW_N;
  wire         in_act    = (tx_st_ff == phm_pkg::TX_ACT);
  wire         in_tail   = (tx_st_ff == phm_pkg::TX_TAIL);
  wire         nxt_line  = in_act && tx_en_s && (tx_cnt_ff >= lat_n - W'(1));
  wire         nxt_col   = in_tail && !spd_s && !tx_en_s
                           && (tx_cnt_ff >= SQE_N - W'(1))
                           && (tx_cnt_ff < SQE_N + PW_N - W'(1));

  always_comb
  begin
    nxt_tx_st  = tx_st_ff;
    nxt_tx_cnt = cnt_inc(tx_cnt_ff);
    nxt_crs_tx = crs_tx_ff;
    case (tx_st_ff)
      phm_pkg::TX_IDLE:
      begin
        nxt_crs_tx = 1'b0;
        if (tx_en_s)
        begin
          nxt_tx_st  = phm_pkg::TX_ACT;
          nxt_tx_cnt = '0;
        end
      end
      phm_pkg::TX_ACT:
      begin
        if (tx_cnt_ff >= crs_on_n - W'(1))
          nxt_crs_tx = 1'b1;
        if (!tx_en_s)
        begin
          nxt_tx_st  = phm_pkg::TX_TAIL;
          nxt_tx_cnt = '0;
        end
      end
      phm_pkg::TX_TAIL:
      begin
        if (tx_en_s)
        begin
          nxt_tx_st  = phm_pkg::TX_ACT;
          nxt_tx_cnt = '0;
        end
        else
        begin
          if (tx_cnt_ff >= crs_off_n - W'(1))
            nxt_crs_tx = 1'b0;
          if (tx_cnt_ff >= tail_n - W'(1))
            nxt_tx_st = phm_pkg::TX_IDLE;
        end
      end
      default:
      begin
        nxt_tx_st  = phm_pkg::TX_IDLE;
        nxt_crs_tx = 1'b0;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      tx_st_ff   <= phm_pkg::TX_IDLE;
      tx_cnt_ff  <= '0;
      crs_tx_ff  <= phm_pkg::CRS_RST;
      line10_ff  <= 1'b0;
      line100_ff <= 1'b0;
      col_ff     <= phm_pkg::COL_RST;
    end
    else
    begin
      tx_st_ff   <= nxt_tx_st;
      tx_cnt_ff  <= nxt_tx_cnt;
      crs_tx_ff  <= nxt_crs_tx;
      line10_ff  <= nxt_line & ~spd_s;
      line100_ff <= nxt_line & spd_s;
      col_ff     <= nxt_col;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Core domain: receive-side carrier and data valid
  phm_pkg::phm_rx_st_t rx_st_ff;
  phm_pkg::phm_rx_st_t nxt_rx_st;
  logic [W-1:0]        rx_cnt_ff;
  logic [W-1:0]        nxt_rx_cnt;
  logic                crs_rx_ff;
  logic                nxt_crs_rx;
  logic                nxt_rxdv_c;

  localparam logic [W-1:0] RON_N  = W'(phm_pkg::RX_CRS_ON_CYC);
  localparam logic [W-1:0] ROFF_N = W'(phm_pkg::RX_CRS_OFF_CYC);
  localparam logic [W-1:0] RDV_N  = W'(phm_pkg::RX_CRS_ON_CYC + phm_pkg::RX_LAT_CYC);

  always_comb
  begin
    nxt_rx_st  = rx_st_ff;
    nxt_rx_cnt = cnt_inc(rx_cnt_ff);
    nxt_crs_rx = crs_rx_ff;
    nxt_rxdv_c = 1'b0;
    case (rx_st_ff)
      phm_pkg::RX_IDLE:
      begin
        nxt_crs_rx = 1'b0;
        if (line_sos)
        begin
          nxt_rx_st  = phm_pkg::RX_START;
          nxt_rx_cnt = '0;
        end
      end
      phm_pkg::RX_START:
      begin
        if (rx_cnt_ff >= RON_N - W'(1))
          nxt_crs_rx = 1'b1;
        if (line_eos)
        begin
          nxt_rx_st  = phm_pkg::RX_END;
          nxt_rx_cnt = '0;
        end
        else if (rx_cnt_ff == RDV_N - W'(1))
        begin
          nxt_rx_st  = phm_pkg::RX_DATA;
          nxt_rxdv_c = 1'b1;
        end
      end
      phm_pkg::RX_DATA:
      begin
        nxt_rxdv_c = !line_eos;
        if (line_eos)
        begin
          nxt_rx_st  = phm_pkg::RX_END;
          nxt_rx_cnt = '0;
        end
      end
      phm_pkg::RX_END:
      begin
        if (line_sos)
        begin
          nxt_rx_st  = phm_pkg::RX_START;
          nxt_rx_cnt = '0;
        end
        else if (rx_cnt_ff >= ROFF_N - W'(1))
        begin
          nxt_crs_rx = 1'b0;
          nxt_rx_st  = phm_pkg::RX_IDLE;
        end
      end
      default:
      begin
        nxt_rx_st  = phm_pkg::RX_IDLE;
        nxt_crs_rx = 1'b0;
      end
    endcase
  end

  // Two-slot hold so the slow side never reads a slot being rewritten
  wire store = rxdv_c_ff & line_rx_stb;

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rx_st_ff    <= phm_pkg::RX_IDLE;
      rx_cnt_ff   <= '0;
      crs_rx_ff   <= phm_pkg::CRS_RST;
      rxdv_c_ff   <= 1'b0;
      hold_tog_ff <= 1'b0;
      hold_ff[0]  <= 5'h00;
      hold_ff[1]  <= 5'h00;
      crs_ff      <= phm_pkg::CRS_RST;
    end
    else
    begin
      rx_st_ff    <= nxt_rx_st;
      rx_cnt_ff   <= nxt_rx_cnt;
      crs_rx_ff   <= nxt_crs_rx;
      rxdv_c_ff   <= nxt_rxdv_c;
      hold_tog_ff <= hold_tog_ff ^ store;
      if (store)
        hold_ff[~hold_tog_ff] <= {line_rx_err, line_rx_nib};
      crs_ff      <= crs_tx_ff | crs_rx_ff;
    end
  end

  assign crs                    = crs_ff;
  assign col                    = col_ff;
  assign line_transmit_pair_10m = line10_ff;
  assign line_tx_100m           = line100_ff;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks
  property p_crs_on;
    @(posedge core_clk) disable iff (!resetn)
    $rose(crs_tx_ff) |-> in_act && (tx_cnt_ff == crs_on_n) ##1 crs_ff;
  endproperty
  a_crs_on: assert property (p_crs_on) else $error("tx carrier rose late or early");

  property p_crs_off;
    @(posedge core_clk) disable iff (!resetn)
    $fell(crs_tx_ff) |-> (tx_cnt_ff == crs_off_n);
  endproperty
  a_crs_off: assert property (p_crs_off) else $error("tx carrier fell off time");

  property p_lat10;
    @(posedge core_clk) disable iff (!resetn)
    $rose(line10_ff) |-> !spd_s && (tx_cnt_ff == bt_cyc(phm_pkg::TX_LAT10_BT, 1'b0));
  endproperty
  a_lat10: assert property (p_lat10) else $error("10M line start off time");

  property p_lat100;
    @(posedge core_clk) disable iff (!resetn)
    $rose(line100_ff) |-> spd_s && (tx_cnt_ff == bt_cyc(phm_pkg::TX_LAT100_BT, 1'b1));
  endproperty
  a_lat100: assert property (p_lat100) else $error("100M line start off time");

  property p_sqe_start;
    @(posedge core_clk) disable iff (!resetn)
    $rose(col_ff) |-> in_tail && !spd_s && (tx_cnt_ff == SQE_N);
  endproperty
  a_sqe_start: assert property (p_sqe_start) else $error("heartbeat start off time");

  property p_sqe_width;
    @(posedge core_clk) disable iff (!resetn)
    $fell(col_ff) && !in_act |-> (tx_cnt_ff == SQE_N + PW_N);
  endproperty
  a_sqe_width: assert property (p_sqe_width) else $error("heartbeat width wrong");

  property p_rx_lat;
    @(posedge core_clk) disable iff (!resetn)
    $rose(rxdv_c_ff) |-> crs_rx_ff && (rx_cnt_ff == RDV_N);
  endproperty
  a_rx_lat: assert property (p_rx_lat) else $error("rx data valid off time");

  property p_rx_crs_on;
    @(posedge core_clk) disable iff (!resetn)
    $rose(crs_rx_ff) |-> (rx_cnt_ff == RON_N) ##1 crs_ff;
  endproperty
  a_rx_crs_on: assert property (p_rx_crs_on) else $error("rx carrier rose off time");

  property p_rx_crs_off;
    @(posedge core_clk) disable iff (!resetn)
    $fell(crs_rx_ff) |-> (rx_cnt_ff == ROFF_N) && !rxdv_c_ff;
  endproperty
  a_rx_crs_off: assert property (p_rx_crs_off) else $error("rx carrier fell off time");

endmodule

// File: verif/phm_mac_model.sv
// MII MAC partner model: sends transmit frames, samples the receive side
module phm_mac_model (
  input  wire logic       mii_clk,
  input  wire logic       rx_dv,
  input  wire logic       rx_er,
  input  wire logic [3:0] rxd,
  output logic            tx_en,
  output logic            tx_er,
  output logic [3:0]      txd
);
  timeunit 1ns;
  timeprecision 1ps;

  integer     seed = 32'h6d1e;
  time        t_on;
  time        t_off;
  logic [4:0] rx_cap;
  logic       dv_cap;

  initial
  begin
    tx_en = 1'b0;
    tx_er = 1'b0;
    txd   = 4'h0;
  end

  ////////////////////////////////////////
  // Receive signals taken on the rising edge only
  always @(posedge mii_clk)
  begin
    rx_cap <= {rx_er, rxd};
    dv_cap <= rx_dv;
  end

  // t_on and t_off are the edges at which the device samples the enable
  task automatic send(input int n);
    int i;
    @(posedge mii_clk);
    for (i = 0; i < n; i++)
    begin
      tx_en <= 1'b1;
      tx_er <= 1'($random(seed));
      txd   <= 4'($random(seed));
      @(posedge mii_clk);
      if (i == 0)
        t_on = $time;
    end
    tx_en <= 1'b0;
    tx_er <= 1'b0;
    // Nibble lines are meaningless outside a frame, so keep them moving
    txd   <= ~txd;
    @(posedge mii_clk);
    t_off = $time;
  endtask
endmodule

// File: verif/phm_datapath_test.sv
// Self-checking bench for the MII datapath timing block
`define CHK(g, e) \
  begin \
    checked++; \
    if ((g) !== (e)) \
    begin \
      n_fail++; \
      $display("mismatch at %0t: got %0h expected %0h", $time, (g), (e)); \
    end \
  end

module phm_datapath_test;
  timeunit 1ns;
  timeprecision 1ps;

  logic       core_clk = 1'b0;
  logic       mii_clk  = 1'b0;
  logic       resetn;
  logic       spd_100_pin;
  logic       line_sos;
  logic       line_eos;
  logic       line_rx_stb;
  logic [3:0] line_rx_nib;
  logic       line_rx_err;
  logic       tx_en;
  logic       tx_er;
  logic [3:0] txd;
  logic       crs;
  logic       col;
  logic [3:0] rxd;
  logic       rx_er;
  logic       rx_dv;
  logic       l10;
  logic       l100;
  logic [3:0] ltx_nib;
  logic       ltx_err;
  logic [4:0] p_tx;
  logic       p_en = 1'b0;
  integer     seed = 32'h6d1e;
  int         n_fail = 0;
  int         checked = 0;
  time        t_crs_r = 0;
  time        t_crs_f = 0;
  time        t_col_r = 0;
  time        t_col_f = 0;
  time        t_l10 = 0;
  time        t_l100 = 0;
  time        t_dv = 0;

  phm_datapath u_phm_datapath (
    .core_clk               (core_clk),
    .resetn                 (resetn),
    .mii_clk                (mii_clk),
    .spd_100_pin            (spd_100_pin),
    .tx_en                  (tx_en),
    .tx_er                  (tx_er),
    .txd                    (txd),
    .crs                    (crs),
    .col                    (col),
    .rxd                    (rxd),
    .rx_er                  (rx_er),
    .rx_dv                  (rx_dv),
    .line_sos               (line_sos),
    .line_eos               (line_eos),
    .line_rx_stb            (line_rx_stb),
    .line_rx_nib            (line_rx_nib),
    .line_rx_err            (line_rx_err),
    .line_transmit_pair_10m (l10),
    .line_tx_100m           (l100),
    .line_tx_nib            (ltx_nib),
    .line_tx_err            (ltx_err)
  );

  phm_mac_model u_phm_mac_model (
    .mii_clk (mii_clk),
    .rx_dv   (rx_dv),
    .rx_er   (rx_er),
    .rxd     (rxd),
    .tx_en   (tx_en),
    .tx_er   (tx_er),
    .txd     (txd)
  );

  initial
  begin
    forever #2.5 core_clk = ~core_clk;
  end

  // Early first rise so reset spans two link edges
  initial
  begin
    #0.7;
    forever
    begin
      mii_clk = ~mii_clk;
      #16;
    end
  end

  ////////////////////////////////////////
  // Event stamps, taken when the output actually moves
  always @(posedge crs) t_crs_r = $time;
  always @(negedge crs) t_crs_f = $time;
  always @(posedge col) t_col_r = $time;
  always @(negedge col) t_col_f = $time;
  always @(posedge l10) t_l10 = $time;
  always @(posedge l100) t_l100 = $time;
  always @(posedge rx_dv) t_dv = $time;

  // Line nibble must be the one sampled one link edge earlier
  always @(negedge mii_clk)
  begin
    if (p_en && resetn)
      `CHK({ltx_err, ltx_nib}, p_tx)
    p_tx = {tx_er, txd};
    p_en = tx_en;
  end

  // Latencies are typical figures; allow for sync and output flops
  function automatic logic in_win(time d, time nom, time tol);
    return (d >= nom) && (d <= nom + tol);
  endfunction

  task automatic tx_frame(input logic s, input int n);
    time bt;
    bt = s ? 64'd10 : 64'd100;
    u_phm_mac_model.send(n);
    `CHK(in_win(t_crs_r - u_phm_mac_model.t_on, 4 * bt, 30), 1'b1)
    if (s)
      `CHK(in_win(t_l100 - u_phm_mac_model.t_on, 9 * bt, 30), 1'b1)
    else
      `CHK(in_win(t_l10 - u_phm_mac_model.t_on, 4 * bt, 30), 1'b1)
    repeat (800) @(posedge core_clk);
    `CHK(in_win(t_crs_f - u_phm_mac_model.t_off, (s ? 4 : 8) * bt, 30), 1'b1)
    if (s)
      `CHK(t_col_r < u_phm_mac_model.t_off, 1'b1)
    else
    begin
      `CHK(in_win(t_col_r - u_phm_mac_model.t_off, 2500, 30), 1'b1)
      `CHK(t_col_f - t_col_r, 64'd1000)
    end
    $display("test tx_frame speed %0d done", s);
  endtask

  task automatic rx_frame(input int n);
    int         i;
    time        ts;
    logic [4:0] v;
    @(posedge core_clk) line_sos <= 1'b1;
    @(posedge core_clk) line_sos <= 1'b0;
    ts = $time;
    for (i = 0; i < 200 && u_phm_mac_model.dv_cap !== 1'b1; i++)
      @(posedge core_clk);
    `CHK(in_win(t_crs_r - ts, 106, 32), 1'b1)
    `CHK(in_win(t_dv - t_crs_r, 60, 128), 1'b1)
    for (i = 0; i < n; i++)
    begin
      v = 5'($random(seed));
      @(posedge core_clk);
      line_rx_stb <= 1'b1;
      line_rx_nib <= v[3:0];
      line_rx_err <= v[4];
      @(posedge core_clk);
      line_rx_stb <= 1'b0;
      repeat (6) @(posedge mii_clk);
      `CHK(u_phm_mac_model.rx_cap, v)
    end
    @(posedge core_clk) line_eos <= 1'b1;
    @(posedge core_clk) line_eos <= 1'b0;
    ts = $time;
    repeat (60) @(posedge core_clk);
    `CHK(in_win(t_crs_f - ts, 154, 32), 1'b1)
    `CHK(u_phm_mac_model.dv_cap, 1'b0)
    $display("test rx_frame done");
  endtask

  task automatic print_verdict;
    $display("counts: checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  ////////////////////////////////////////
  initial
  begin
    resetn      = 1'b0;
    spd_100_pin = 1'b1;
    line_sos    = 1'b0;
    line_eos    = 1'b0;
    line_rx_stb = 1'b0;
    line_rx_nib = 4'h0;
    line_rx_err = 1'b0;
    repeat (10) @(posedge core_clk);
    resetn <= 1'b1;
    repeat (4) @(posedge core_clk);
    // Enable shorter than four bit times must not raise carrier
    u_phm_mac_model.send(1);
    repeat (40) @(posedge core_clk);
    `CHK(t_crs_r < u_phm_mac_model.t_on, 1'b1)
    $display("test short_enable done");
    tx_frame(1'b1, 24);
    tx_frame(1'b1, 4);
    rx_frame(6);
    // Speed only changes under reset, also exercising a mid-run reset
    resetn      <= 1'b0;
    spd_100_pin <= 1'b0;
    repeat (16) @(posedge core_clk);
    resetn <= 1'b1;
    repeat (4) @(posedge core_clk);
    tx_frame(1'b0, 20);
    tx_frame(1'b0, 14);
    print_verdict;
  end

  initial
  begin
    #100000;
    n_fail++;
    print_verdict;
  end
endmodule
